// ==== rtl/pss_regs.svh ====
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_CLK_HZ          50000000
`define PSS_SS_US           1000
`define PSS_GATE_US         3750
`define PSS_RAILB_US        7500
`define PSS_LDO_US          8500
`define PSS_QUAL_US         1000
`define PSS_RST_DLY_US      30000
`define PSS_US_CYC(us)      (((us) * (`PSS_CLK_HZ / 1000)) / 1000)
`define PSS_SEQ_W           20
`define PSS_RST_W           21
`endif

// ==== rtl/pss_pkg.sv ====
package pss_pkg;
   typedef enum logic [3:0] {
      PSS_LOCKED  = 4'h1,
      PSS_RUN     = 4'h2,
      PSS_PROTECT = 4'h4,
      PSS_HALT    = 4'h8
   } pss_state_t;
endpackage

// ==== rtl/pss_sync.sv ====
`timescale 1ns/10ps
module pss_sync
   #(parameter int W = 1)
   (
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
   );
   logic [W-1:0] meta_reg;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ==== rtl/pss_sequencer.sv ====
`timescale 1ns/10ps
`include "pss_regs.svh"
module pss_sequencer
   import pss_pkg::*;
   #(
   parameter int SEQ_MAX_CYC = `PSS_US_CYC(`PSS_LDO_US),
   parameter int QUAL_CYC    = `PSS_US_CYC(`PSS_QUAL_US),
   parameter int RST_DLY_CYC = `PSS_US_CYC(`PSS_RST_DLY_US),
   parameter int SS_CYC      = `PSS_US_CYC(`PSS_SS_US),
   parameter int GATE_CYC    = `PSS_US_CYC(`PSS_GATE_US),
   parameter int RAILB_CYC   = `PSS_US_CYC(`PSS_RAILB_US)
   )
   (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic enable_in,
   input  wire logic supply_good,
   input  wire logic supply_low,
   input  wire logic reset_good,
   input  wire logic rail_a_short,
   input  wire logic rail_b_short,
   input  wire logic ldo_short,
   input  wire logic thermal_shutdown,
   input  wire logic regulator_short,
   output logic      undervoltage_lockout,
   output logic      buck_rail_a,
   output logic      rail_a_soft_start,
   output logic      buck_rail_b,
   output logic      rail_b_soft_start,
   output logic      ldo_rail_en,
   output logic      pfet_gate_ramp,
   output logic      switch_sync_flag,
   output logic      bleed_termination,
   output logic      rail_a_feedback_term,
   output logic      rail_b_feedback_term,
   output logic      ldo_output_term,
   output logic      supervisor_reset_out,
   output logic      supervisor_reset_oe_n,
   output logic      protect_latched
   );
   localparam logic [`PSS_SEQ_W-1:0] SS_C    = `PSS_SEQ_W'(SS_CYC);
   localparam logic [`PSS_SEQ_W-1:0] GATE_C  = `PSS_SEQ_W'(GATE_CYC);
   localparam logic [`PSS_SEQ_W-1:0] RAILB_C = `PSS_SEQ_W'(RAILB_CYC);
   localparam logic [`PSS_SEQ_W-1:0] LDO_C   = `PSS_SEQ_W'(SEQ_MAX_CYC);
   localparam logic [`PSS_SEQ_W-1:0] QUAL_C  = `PSS_SEQ_W'(QUAL_CYC);
   localparam logic [`PSS_RST_W-1:0] RST_C   = `PSS_RST_W'(RST_DLY_CYC);

   logic [6:0] pin_raw;
   logic [6:0] pin_s;
   logic       en_s;
   logic       good_s;
   logic       low_s;
   logic       rgood_s;
   logic       short_a_s;
   logic       short_b_s;
   logic       therm_s;
   logic       regsh_n_unused;
   pss_state_t              state_reg;
   pss_state_t              state_next;
   logic [`PSS_SEQ_W-1:0]   seq_cnt_reg;
   logic [`PSS_SEQ_W-1:0]   qual_cnt_reg;
   logic [`PSS_RST_W-1:0]   rst_cnt_reg;
   logic                    en_prev_reg;
   logic                    rst_rel_reg;
   logic                    regsh_s;
   logic                    regsh_meta_reg;
   logic [`PSS_SEQ_W-1:0]   seq_cnt_next;
   logic                    run_next;
   logic                    lockout_reg;
   logic                    rail_a_reg;
   logic                    soft_a_reg;
   logic                    rail_b_reg;
   logic                    soft_b_reg;
   logic                    ldo_reg;
   logic                    ramp_reg;
   logic                    sync_reg;
   logic                    bleed_reg;
   logic                    term_reg;
   logic                    oe_n_reg;
   logic                    protect_reg;
   logic                    rail_a_next;
   logic                    soft_a_next;
   logic                    rail_b_next;
   logic                    soft_b_next;
   logic                    ldo_next;
   logic                    ramp_next;
   logic                    term_next;
   logic                    oe_n_next;
   logic                    protect_next;

   assign pin_raw = {thermal_shutdown, rail_b_short, rail_a_short, reset_good,
                     supply_low, supply_good, enable_in};

   pss_sync #(.W(7)) u_sync
   (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .async_in (pin_raw),
      .sync_out (pin_s)
   );

   assign en_s      = pin_s[0];
   assign good_s    = pin_s[1];
   assign low_s     = pin_s[2];
   assign rgood_s   = pin_s[3];
   assign short_a_s = pin_s[4];
   assign short_b_s = pin_s[5];
   assign therm_s   = pin_s[6];
   // LDO short flag is deliberately left out of fault logic
   // LDO short ignored
   assign regsh_n_unused = ldo_short;

   // Regulator short synchroniser
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         regsh_meta_reg <= 1'b0;
         regsh_s        <= 1'b0;
      end
      else
      begin
         regsh_meta_reg <= regulator_short;
         regsh_s        <= regsh_meta_reg;
      end
   end

   wire running    = (state_reg == PSS_RUN);
   wire release_ok = en_s && good_s && !low_s && !regsh_s;
   wire lockout    = low_s || !en_s;
   wire en_rise    = en_s && !en_prev_reg;
   wire fault_raw  = short_a_s || short_b_s || therm_s;
   wire fault_hit  = fault_raw && (qual_cnt_reg >= QUAL_C - 1'b1);

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PSS_LOCKED:
            if (release_ok)
               state_next = PSS_RUN;
         PSS_RUN:
            if (regsh_s)
               state_next = PSS_HALT;
            else if (lockout)
               state_next = PSS_LOCKED;
            else if (fault_hit)
               state_next = PSS_PROTECT;
         PSS_PROTECT:
            if (lockout || en_rise)
               state_next = PSS_LOCKED;
         PSS_HALT:
            if (!regsh_s)
               state_next = PSS_LOCKED;
         default:
            state_next = PSS_LOCKED;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_reg   <= PSS_LOCKED;
         en_prev_reg <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         en_prev_reg <= en_s;
      end
   end

   assign seq_cnt_next = !running ? '0 :
                         (seq_cnt_reg < LDO_C) ? seq_cnt_reg + 1'b1 : seq_cnt_reg;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         seq_cnt_reg <= '0;
      else
         seq_cnt_reg <= seq_cnt_next;
   end

   // Fault qualification counter
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !running || !fault_raw)
         qual_cnt_reg <= '0;
      else if (qual_cnt_reg < QUAL_C)
         qual_cnt_reg <= qual_cnt_reg + 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !rgood_s)
      begin
         rst_cnt_reg <= '0;
         rst_rel_reg <= 1'b0;
      end
      else if (rst_cnt_reg < RST_C - 1'b1)
         rst_cnt_reg <= rst_cnt_reg + 1'b1;
      else
         rst_rel_reg <= 1'b1;
   end

   // rail A on at release, off on lockout
   assign run_next     = (state_next == PSS_RUN);
   assign rail_a_next  = run_next;
   assign soft_a_next  = run_next && (seq_cnt_next < SS_C);
   assign ramp_next    = run_next && (seq_cnt_next >= GATE_C);
   assign rail_b_next  = run_next && (seq_cnt_next >= RAILB_C);
   assign soft_b_next  = rail_b_next && (seq_cnt_next < RAILB_C + SS_C);
   assign ldo_next     = run_next && (seq_cnt_next >= LDO_C);
   assign term_next    = !en_s;
   assign oe_n_next    = rst_rel_reg && rgood_s;
   assign protect_next = (state_next == PSS_PROTECT);

   // Rail enable flops
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         lockout_reg <= 1'b1;
         rail_a_reg  <= 1'b0;
         soft_a_reg  <= 1'b0;
         rail_b_reg  <= 1'b0;
         soft_b_reg  <= 1'b0;
         ldo_reg     <= 1'b0;
      end
      else
      begin
         lockout_reg <= !run_next;
         rail_a_reg  <= rail_a_next;
         soft_a_reg  <= soft_a_next;
         rail_b_reg  <= rail_b_next;
         soft_b_reg  <= soft_b_next;
         ldo_reg     <= ldo_next;
      end
   end

   // Gate drive flops
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ramp_reg  <= 1'b0;
         sync_reg  <= 1'b0;
         bleed_reg <= 1'b1;
      end
      else
      begin
         ramp_reg  <= ramp_next;
         sync_reg  <= ramp_next;
         bleed_reg <= !ramp_next;
      end
   end

   // Termination, reset pin and status flops
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         term_reg    <= 1'b1;
         oe_n_reg    <= 1'b0;
         protect_reg <= 1'b0;
      end
      else
      begin
         term_reg    <= term_next;
         oe_n_reg    <= oe_n_next;
         protect_reg <= protect_next;
      end
   end

   assign undervoltage_lockout  = lockout_reg;
   assign buck_rail_a           = rail_a_reg;
   assign rail_a_soft_start     = soft_a_reg;
   assign buck_rail_b           = rail_b_reg;
   assign rail_b_soft_start     = soft_b_reg;
   assign ldo_rail_en           = ldo_reg;
   assign pfet_gate_ramp        = ramp_reg;
   assign switch_sync_flag      = sync_reg;
   assign bleed_termination     = bleed_reg;
   assign rail_a_feedback_term  = term_reg;
   assign rail_b_feedback_term  = term_reg;
   assign ldo_output_term       = term_reg;
   // Open-drain pin only ever pulls low
   assign supervisor_reset_out  = 1'b0;
   assign supervisor_reset_oe_n = oe_n_reg;
   assign protect_latched       = protect_reg;
endmodule

// ==== verification/pss_rail_model.sv ====
`timescale 1ns/10ps
module pss_rail_model (
   input  wire logic buck_rail_a,
   input  wire logic buck_rail_b,
   input  wire logic short_a_cmd,
   input  wire logic short_b_cmd,
   output logic      rail_a_short,
   output logic      rail_b_short
);
   assign rail_a_short = buck_rail_a & short_a_cmd;
   assign rail_b_short = buck_rail_b & short_b_cmd;
endmodule

// ==== verification/pss_sequencer_checker.sv ====
`timescale 1ns/10ps
module pss_sequencer_checker (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic enable_in,
   input wire logic reset_good,
   input wire logic regulator_short,
   input wire logic undervoltage_lockout,
   input wire logic buck_rail_a,
   input wire logic buck_rail_b,
   input wire logic ldo_rail_en,
   input wire logic pfet_gate_ramp,
   input wire logic switch_sync_flag,
   input wire logic bleed_termination,
   input wire logic rail_a_feedback_term,
   input wire logic supervisor_reset_oe_n,
   input wire logic protect_latched
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_lock; undervoltage_lockout |-> !(buck_rail_a | buck_rail_b | ldo_rail_en); endproperty
   a_lock: assert property (p_lock) else $error("rail on in lockout");
   property p_sync; switch_sync_flag == pfet_gate_ramp; endproperty
   a_sync: assert property (p_sync) else $error("sync flag differs");
   property p_bleed; pfet_gate_ramp |-> !bleed_termination; endproperty
   a_bleed: assert property (p_bleed) else $error("bleed on with ramp");
   property p_prot;
      protect_latched |-> !(buck_rail_a | buck_rail_b | ldo_rail_en | pfet_gate_ramp);
   endproperty
   a_prot: assert property (p_prot) else $error("output on in protect");
   property p_rlow; $fell(reset_good) |-> ##[1:3] !supervisor_reset_oe_n; endproperty
   a_rlow: assert property (p_rlow) else $error("reset not driven");
   property p_rkeep; $rose(protect_latched) |-> $stable(supervisor_reset_oe_n); endproperty
   a_rkeep: assert property (p_rkeep) else $error("reset moved");
   property p_term; !enable_in [*4] |-> rail_a_feedback_term; endproperty
   a_term: assert property (p_term) else $error("no termination");
   property p_regs; regulator_short [*4] |-> undervoltage_lockout && !buck_rail_a; endproperty
   a_regs: assert property (p_regs) else $error("run in reg short");
endmodule
bind pss_sequencer pss_sequencer_checker chk_u (.*);

// ==== verification/power_up_sequencer_fault_latch_test.sv ====
`timescale 1ns/10ps
module power_up_sequencer_fault_latch_test;
   logic ref_clk, sys_rst, enable_in, supply_good, supply_low, reset_good, ldo_short;
   logic thermal_shutdown, regulator_short, short_a_cmd, short_b_cmd, rail_a_short;
   logic rail_b_short, undervoltage_lockout, buck_rail_a, rail_a_soft_start, buck_rail_b;
   logic rail_b_soft_start, ldo_rail_en, pfet_gate_ramp, switch_sync_flag, bleed_termination;
   logic rail_a_feedback_term, rail_b_feedback_term, ldo_output_term, supervisor_reset_out;
   logic supervisor_reset_oe_n, protect_latched;
   logic [4:0] obs;
   int         n_mismatch = 0;
   int         n_tests = 0;
   int         c;
   assign obs = {supervisor_reset_oe_n, ldo_rail_en, buck_rail_b, pfet_gate_ramp, buck_rail_a};
   pss_sequencer #(.SEQ_MAX_CYC(40), .QUAL_CYC(10), .RST_DLY_CYC(50),
      .GATE_CYC(15), .RAILB_CYC(30)) dut_u (.*);
   pss_rail_model rail_u (.*);
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic chk(input logic [31:0] got, input int lo, input int hi);
      n_tests++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         n_mismatch++;
         $display("mismatch at %0t got %0h want %0h..%0h", $time, got, lo, hi);
      end
   endtask
   task automatic tally_and_finish;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Counts cycles until an output rises, bounded
   task automatic wait_obs(input int i, input int lo, input int hi);
      c = 0;
      while (obs[i] !== 1'b1 && c < 200)
      begin
         tick(1);
         c++;
      end
      chk(c, lo, hi);
      if (c >= 200)
         tally_and_finish();
   endtask
   task automatic bring_up;
      enable_in = 1'b1;
      supply_good = 1'b1;
      wait_obs(0, 2, 5);
      chk(rail_a_soft_start, 1, 1);
      wait_obs(1, 14, 16);
      chk({switch_sync_flag, bleed_termination}, 2, 2);
      wait_obs(2, 14, 16);
      wait_obs(3, 9, 11);
      // Soft-start window is 1 ms at 50 MHz, past the 40-cycle count cap, so both soft-starts stay on
      chk({rail_a_soft_start, rail_b_soft_start}, 3, 3);
      chk({rail_a_feedback_term, rail_b_feedback_term, ldo_output_term}, 0, 0);
   endtask
   initial
   begin
      {sys_rst, enable_in, supply_good, supply_low, reset_good, ldo_short} = 6'h20;
      {thermal_shutdown, regulator_short, short_a_cmd, short_b_cmd} = 4'h0;
      tick(20);
      sys_rst = 1'b0;
      tick(2);
      chk({undervoltage_lockout, bleed_termination, supervisor_reset_oe_n}, 6, 6);
      reset_good = 1'b1;
      wait_obs(4, 51, 54);
      bring_up();
      $display("test start done");
      ldo_short = 1'b1;
      tick(20);
      chk(protect_latched, 0, 0);
      ldo_short = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         {short_a_cmd, short_b_cmd, thermal_shutdown} = 3'h4 >> k;
         tick(6);
         {short_a_cmd, short_b_cmd, thermal_shutdown} = 3'h0;
         tick(3);
         chk(protect_latched, 0, 0);
         {short_a_cmd, short_b_cmd, thermal_shutdown} = 3'h4 >> k;
         tick(16);
         chk({protect_latched, obs}, 6'h30, 6'h30);
         {short_a_cmd, short_b_cmd, thermal_shutdown} = 3'h0;
         tick(5);
         chk(protect_latched, 1, 1);
         enable_in = 1'b0;
         tick(4);
         chk({rail_a_feedback_term, rail_b_feedback_term, ldo_output_term}, 7, 7);
         bring_up();
         $display("test fault %0d done", k);
      end
      regulator_short = 1'b1;
      tick(4);
      chk({undervoltage_lockout, obs[3:0]}, 5'h10, 5'h10);
      regulator_short = 1'b0;
      wait_obs(0, 2, 8);
      wait_obs(3, 39, 41);
      supply_low = 1'b1;
      reset_good = 1'b0;
      tick(4);
      chk({obs, bleed_termination, switch_sync_flag}, 7'h02, 7'h02);
      chk(supervisor_reset_out, 0, 0);
      $display("test lockout done");
      tally_and_finish();
   end
endmodule
